//--- hw/ccr_consts.svh
// Constants for the transceiver main control register block
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

`define CCR_ADDR_W           4
`define CCR_ADDR_MAIN        4'h4
`define CCR_REG_W            32
`define CCR_RESET_VALUE      32'h1000_0270
`define CCR_CNT_FULL         6'h20

`define CCR_BIT_POWER        31
`define CCR_BIT_DIRECTION    30
`define CCR_BIT_RECCLK       29
`define CCR_BIT_LOCKONLY     28
`define CCR_BIT_AMP          27
`define CCR_BIT_WAKEUP       26
`define CCR_BIT_GAIN         25
`define CCR_BIT_SUPPLY       24
`define CCR_THR_MSB          23
`define CCR_THR_LSB          18
`define CCR_HYS_MSB          17
`define CCR_HYS_LSB          15
`define CCR_LVL_MSB          14
`define CCR_LVL_LSB          12
`define CCR_BIT_TXCODE       11
`define CCR_RXC_MSB          9
`define CCR_RXC_LSB          8
`define CCR_BIT_CRYSTAL      7
`define CCR_BIT_RANGE        6
`define CCR_BIT_POLARITY     5
`define CCR_BIT_SLICER       4
`define CCR_BIT_ADCDISC      1

`endif

//--- hw/ccr_main_control.sv
// Main control register with its serial access port and derived controls
`timescale 1ns/1ps
`include "ccr_consts.svh"
module ccr_main_control #(
	parameter int STRENGTH_W = 6
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire logic                  ser_enable_n,
	input  wire logic                  ser_clk,
	input  wire logic                  ser_data_in,
	output logic                       ser_data_out,
	output logic                       ser_data_oe,
	input  wire logic                  synth_lock_flag,
	input  wire logic                  recovered_clock_in,
	input  wire logic                  demod_data,
	input  wire logic                  tx_data,
	input  wire logic                  strength_sample,
	input  wire logic [STRENGTH_W-1:0] measured_strength,
	output logic [`CCR_REG_W-1:0]      main_control,
	output logic                       general_power_on,
	output logic                       direction_select,
	output logic                       recovered_clock_enable,
	output logic                       transmit_on_lock_only,
	output logic                       amplifier_enable,
	output logic                       wakeup_enable,
	output logic                       input_gain_select,
	output logic                       supply_measure_select,
	output logic [2:0]                 transmit_level,
	output logic                       transmit_code_select,
	output logic [1:0]                 receive_code_select,
	output logic                       crystal_select,
	output logic                       discriminator_range,
	output logic                       data_polarity,
	output logic                       slicer_reference_select,
	output logic                       adc_discriminator_select,
	output logic                       transmit_allowed,
	output logic                       amplifier_active,
	output logic                       wakeup_active,
	output logic [1:0]                 tx_code_index,
	output logic                       recovered_clock_pin,
	output logic                       radio_data_pin,
	output logic                       data_valid
);

	ccr_pkg::ccr_ser_state_t     state_r;
	ccr_pkg::ccr_ser_state_t     state_nxt;
	logic [`CCR_REG_W-1:0]       main_control_r;
	logic [`CCR_REG_W-1:0]       main_control_nxt;
	logic [`CCR_REG_W-1:0]       shift_r;
	logic [`CCR_REG_W-1:0]       shift_nxt;
	logic [`CCR_ADDR_W-1:0]      addr_r;
	logic [`CCR_ADDR_W-1:0]      addr_nxt;
	logic [5:0]                  cnt_r;
	logic [5:0]                  cnt_nxt;
	logic                        sck_prev_r;
	logic                        out_r;
	logic                        out_nxt;
	logic                        oe_r;
	logic                        oe_nxt;
	logic                        rclk_pin_r;
	logic                        rclk_pin_nxt;
	logic                        data_pin_r;
	logic                        data_pin_nxt;
	logic                        sck_rise;
	logic                        sck_fall;
	logic                        active;
	logic                        own_addr;
	logic                        ctrl_we;
	logic                        strength_valid;

	assign active   = !ser_enable_n;
	assign sck_rise = ser_clk && !sck_prev_r;
	assign sck_fall = !ser_clk && sck_prev_r;
	assign own_addr = (addr_r == `CCR_ADDR_MAIN);

	// Serial access engine
	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		addr_nxt  = addr_r;
		cnt_nxt   = cnt_r;
		out_nxt   = out_r;
		oe_nxt    = oe_r;
		ctrl_we   = 1'b0;
		if (!active) begin
			// Partial writes commit on enable release; LSBs kept from the old value
			if (state_r == ccr_pkg::CCR_WDATA && cnt_r != 6'h00 && own_addr)
				ctrl_we = 1'b1;
			state_nxt = ccr_pkg::CCR_IDLE;
			oe_nxt    = 1'b0;
			out_nxt   = 1'b0;
		end else begin
			unique case (state_r)
				ccr_pkg::CCR_IDLE: begin
					state_nxt = ccr_pkg::CCR_ADDR;
					cnt_nxt   = 6'h00;
					addr_nxt  = 4'h0;
				end
				ccr_pkg::CCR_ADDR: begin
					if (sck_rise) begin
						addr_nxt = {addr_r[`CCR_ADDR_W-2:0], ser_data_in};
						cnt_nxt  = cnt_r + 6'h01;
						if (cnt_r == 6'h03)
							state_nxt = ccr_pkg::CCR_RW;
					end
				end
				ccr_pkg::CCR_RW: begin
					if (sck_rise) begin
						cnt_nxt   = 6'h00;
						shift_nxt = main_control_r;
						state_nxt = ser_data_in ? ccr_pkg::CCR_WDATA : ccr_pkg::CCR_RDATA;
					end
				end
				ccr_pkg::CCR_WDATA: begin
					if (sck_rise) begin
						if (cnt_r == `CCR_CNT_FULL) begin
							// First extra edge commits at once; later bits are dropped
							ctrl_we   = own_addr;
							state_nxt = ccr_pkg::CCR_DONE;
						end else begin
							shift_nxt[5'(31 - cnt_r)] = ser_data_in;
							cnt_nxt = cnt_r + 6'h01;
						end
					end
				end
				ccr_pkg::CCR_RDATA: begin
					if (sck_fall) begin
						// Other addresses belong to other registers; leave the pin alone
						oe_nxt  = own_addr;
						out_nxt = (cnt_r < `CCR_CNT_FULL) ? shift_r[5'(31 - cnt_r)] : 1'b0;
						if (cnt_r < `CCR_CNT_FULL)
							cnt_nxt = cnt_r + 6'h01;
					end
				end
				ccr_pkg::CCR_DONE: begin
					state_nxt = ccr_pkg::CCR_DONE;
				end
			endcase
		end
		if (!ce)
			ctrl_we = 1'b0;
	end

	always_comb begin
		main_control_nxt = main_control_r;
		if (ctrl_we)
			main_control_nxt = shift_r;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r        <= ccr_pkg::CCR_IDLE;
			shift_r        <= 32'h0000_0000;
			addr_r         <= 4'h0;
			cnt_r          <= 6'h00;
			out_r          <= 1'b0;
			oe_r           <= 1'b0;
			sck_prev_r     <= 1'b0;
			main_control_r <= `CCR_RESET_VALUE;
		end else if (ce) begin
			state_r        <= state_nxt;
			shift_r        <= shift_nxt;
			addr_r         <= addr_nxt;
			cnt_r          <= cnt_nxt;
			out_r          <= out_nxt;
			oe_r           <= oe_nxt;
			sck_prev_r     <= ser_clk;
			main_control_r <= main_control_nxt;
		end
	end

	assign ser_data_out = out_r;
	assign ser_data_oe  = oe_r;

	// Field views of the held register
	assign main_control             = main_control_r;
	assign general_power_on         = main_control_r[`CCR_BIT_POWER];
	assign direction_select         = main_control_r[`CCR_BIT_DIRECTION];
	assign recovered_clock_enable   = main_control_r[`CCR_BIT_RECCLK];
	assign transmit_on_lock_only    = main_control_r[`CCR_BIT_LOCKONLY];
	assign amplifier_enable         = main_control_r[`CCR_BIT_AMP];
	assign wakeup_enable            = main_control_r[`CCR_BIT_WAKEUP];
	assign input_gain_select        = main_control_r[`CCR_BIT_GAIN];
	assign supply_measure_select    = main_control_r[`CCR_BIT_SUPPLY];
	assign transmit_level           = main_control_r[`CCR_LVL_MSB:`CCR_LVL_LSB];
	assign transmit_code_select     = main_control_r[`CCR_BIT_TXCODE];
	assign receive_code_select      = main_control_r[`CCR_RXC_MSB:`CCR_RXC_LSB];
	assign crystal_select           = main_control_r[`CCR_BIT_CRYSTAL];
	assign discriminator_range      = main_control_r[`CCR_BIT_RANGE];
	assign data_polarity            = main_control_r[`CCR_BIT_POLARITY];
	assign slicer_reference_select  = main_control_r[`CCR_BIT_SLICER];
	assign adc_discriminator_select = main_control_r[`CCR_BIT_ADCDISC];

	// Derived controls
	assign transmit_allowed = general_power_on && direction_select
		&& (!transmit_on_lock_only || synth_lock_flag);
	assign amplifier_active = amplifier_enable && general_power_on;
	assign wakeup_active    = wakeup_enable;
	assign tx_code_index    = {transmit_code_select, tx_data};

	// ADC busy on supply keeps the last strength verdict
	assign strength_valid = strength_sample && !supply_measure_select && general_power_on;

	ccr_validator #(
		.STRENGTH_W (STRENGTH_W),
		.HYST_W     (3)
	) u_validator (
		.mclk                (mclk),
		.rst                 (rst),
		.ce                  (ce),
		.sample              (strength_valid),
		.measured_strength   (measured_strength),
		.strength_threshold  (main_control_r[`CCR_THR_MSB:`CCR_THR_LSB]),
		.strength_hysteresis (main_control_r[`CCR_HYS_MSB:`CCR_HYS_LSB]),
		.data_valid          (data_valid)
	);

	always_comb begin
		rclk_pin_nxt = recovered_clock_enable && general_power_on && recovered_clock_in;
		data_pin_nxt = 1'b0;
		if (general_power_on && !direction_select && data_valid)
			data_pin_nxt = data_polarity ? demod_data : !demod_data;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rclk_pin_r <= 1'b0;
			data_pin_r <= 1'b0;
		end else if (ce) begin
			rclk_pin_r <= rclk_pin_nxt;
			data_pin_r <= data_pin_nxt;
		end
	end

	assign recovered_clock_pin = rclk_pin_r;
	assign radio_data_pin      = data_pin_r;

	property p_reset_pattern;
		@(posedge mclk) $fell(rst) |-> main_control_r == `CCR_RESET_VALUE;
	endproperty
	a_reset_pattern: assert property (p_reset_pattern) else $error("Register not at reset pattern");

	property p_hold;
		@(posedge mclk) disable iff (rst) !ctrl_we |=> $stable(main_control_r);
	endproperty
	a_hold: assert property (p_hold) else $error("Register changed without a write");

	property p_power_off;
		@(posedge mclk) disable iff (rst) !general_power_on |-> !transmit_allowed && !amplifier_active;
	endproperty
	a_power_off: assert property (p_power_off) else $error("Activity while powered down");

	property p_tx_direction;
		@(posedge mclk) disable iff (rst) transmit_allowed |-> direction_select;
	endproperty
	a_tx_direction: assert property (p_tx_direction) else $error("Transmit allowed in receive mode");

	property p_lock_gate;
		@(posedge mclk) disable iff (rst) (transmit_allowed && transmit_on_lock_only) |-> synth_lock_flag;
	endproperty
	a_lock_gate: assert property (p_lock_gate) else $error("Transmit while unlocked");

	property p_recclk_off;
		@(posedge mclk) disable iff (rst) (ce && !recovered_clock_enable) |=> !recovered_clock_pin;
	endproperty
	a_recclk_off: assert property (p_recclk_off) else $error("Recovered clock driven while disabled");

	property p_amp;
		@(posedge mclk) disable iff (rst) amplifier_active |-> amplifier_enable && general_power_on;
	endproperty
	a_amp: assert property (p_amp) else $error("Amplifier active without enable and power");

	property p_polarity;
		@(posedge mclk) disable iff (rst) (ce && general_power_on && !direction_select && data_valid)
			|=> radio_data_pin == ($past(data_polarity) ? $past(demod_data) : !$past(demod_data));
	endproperty
	a_polarity: assert property (p_polarity) else $error("Received data polarity wrong");

	property p_write_commit;
		@(posedge mclk) disable iff (rst) ctrl_we |=> main_control_r == $past(shift_r);
	endproperty
	a_write_commit: assert property (p_write_commit) else $error("Committed register differs from shifted word");

	property p_rx_only;
		@(posedge mclk) disable iff (rst) (ce && !(general_power_on && !direction_select)) |=> !radio_data_pin;
	endproperty
	a_rx_only: assert property (p_rx_only) else $error("Data pin driven outside powered receive");

	property p_data_inhibit;
		@(posedge mclk) disable iff (rst) (ce && !data_valid) |=> !radio_data_pin;
	endproperty
	a_data_inhibit: assert property (p_data_inhibit) else $error("Data pin driven while inhibited");

	property p_strength_gate;
		@(posedge mclk) disable iff (rst) (ce && strength_sample && supply_measure_select) |=> $stable(data_valid);
	endproperty
	a_strength_gate: assert property (p_strength_gate) else $error("Validation moved while measuring supply");

	property p_recclk_pass;
		@(posedge mclk) disable iff (rst) (ce && recovered_clock_enable && general_power_on)
			|=> recovered_clock_pin == $past(recovered_clock_in);
	endproperty
	a_recclk_pass: assert property (p_recclk_pass) else $error("Recovered clock not passed to pin");

endmodule : ccr_main_control

//--- hw/ccr_pkg.sv
// Types for the transceiver main control register block
package ccr_pkg;

	typedef enum logic [2:0] {
		CCR_IDLE,
		CCR_ADDR,
		CCR_RW,
		CCR_WDATA,
		CCR_RDATA,
		CCR_DONE
	} ccr_ser_state_t;

endpackage : ccr_pkg

//--- hw/ccr_validator.sv
// Signal strength validation with hysteresis
`timescale 1ns/1ps
module ccr_validator #(
	parameter int STRENGTH_W = 6,
	parameter int HYST_W     = 3
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire logic                  sample,
	input  wire logic [STRENGTH_W-1:0] measured_strength,
	input  wire logic [STRENGTH_W-1:0] strength_threshold,
	input  wire logic [HYST_W-1:0]     strength_hysteresis,
	output logic                       data_valid
);

	logic              valid_r;
	logic              valid_nxt;
	logic [STRENGTH_W:0] high_level;
	logic [STRENGTH_W:0] meas_plus_hys;
	logic              at_or_above_high;
	logic              below_low;

	assign high_level       = {1'b0, strength_threshold} + (STRENGTH_W+1)'(strength_hysteresis);
	assign meas_plus_hys    = {1'b0, measured_strength} + (STRENGTH_W+1)'(strength_hysteresis);
	assign at_or_above_high = {1'b0, measured_strength} >= high_level;
	// Compared as m + h < t so a negative low level never underflows
	assign below_low        = meas_plus_hys < {1'b0, strength_threshold};

	always_comb begin
		valid_nxt = valid_r;
		if (ce && sample) begin
			if (at_or_above_high)
				valid_nxt = 1'b1;
			else if (below_low)
				valid_nxt = 1'b0;
			else
				valid_nxt = valid_r;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			valid_r <= 1'b0;
		else
			valid_r <= valid_nxt;
	end

	assign data_valid = valid_r;

	property p_validate_high;
		@(posedge mclk) disable iff (rst) (ce && sample && at_or_above_high) |=> valid_r;
	endproperty
	a_validate_high: assert property (p_validate_high) else $error("Strength above high level not validated");

	property p_inhibit_low;
		@(posedge mclk) disable iff (rst) (ce && sample && below_low) |=> !valid_r;
	endproperty
	a_inhibit_low: assert property (p_inhibit_low) else $error("Strength below low level not inhibited");

	property p_hold_between;
		@(posedge mclk) disable iff (rst) (!(ce && sample) || (!at_or_above_high && !below_low)) |=> $stable(valid_r);
	endproperty
	a_hold_between: assert property (p_hold_between) else $error("Validation changed inside hysteresis band");

endmodule : ccr_validator

//--- testbench/ccr_host_model.sv
// Controller model driving the three-wire serial port
`timescale 1ns/1ps
module ccr_host_model (
	input  wire logic mclk,
	output logic      ser_enable_n,
	output logic      ser_clk,
	output logic      ser_data_in,
	input  wire logic ser_data_out,
	input  wire logic ser_data_oe
);
	initial begin
		ser_enable_n = 1'b1;
		ser_clk      = 1'b0;
		ser_data_in  = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
		#10;
	endtask : hold

	// Three cycles per level, above the two-cycle minimum
	task automatic put_bit(input logic b);
		ser_clk     = 1'b0;
		ser_data_in = b;
		hold(3);
		ser_clk = 1'b1;
		hold(3);
	endtask : put_bit

	task automatic xfer(input logic [3:0] addr, input logic wr, input int nbits, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic oe_seen);
		logic [31:0] wbits;
		wbits   = wdata & ~32'h0000_040d;
		rdata   = 32'h0000_0000;
		oe_seen = 1'b0;
		hold(1);
		ser_enable_n = 1'b0;
		hold(1);
		for (int i = 0; i < 4; i++) begin
			put_bit(addr[3-i]);
		end
		put_bit(wr);
		for (int i = 0; i < nbits; i++) begin
			if (wr) begin
				put_bit(wbits[31-i]);
			end else begin
				ser_clk     = 1'b0;
				// Released line must not show a stale value
				ser_data_in = ~ser_data_in;
				hold(3);
				rdata[31-i] = ser_data_out;
				oe_seen     = oe_seen | ser_data_oe;
				ser_clk     = 1'b1;
				hold(3);
			end
		end
		ser_clk = 1'b0;
		hold(3);
		ser_enable_n = 1'b1;
		ser_data_in  = 1'b0;
		hold(3);
	endtask : xfer
endmodule : ccr_host_model

//--- testbench/ccr_main_control_bench.sv
// Self-checking bench for the main control register block
`timescale 1ns/1ps
module ccr_main_control_bench;
	logic        mclk, rst, ce, synth_lock_flag, recovered_clock_in, demod_data, tx_data, strength_sample;
	logic [5:0]  measured_strength;
	logic        ser_enable_n, ser_clk, ser_data_in, ser_data_out, ser_data_oe;
	logic [31:0] main_control, d, w;
	logic        general_power_on, direction_select, recovered_clock_enable, transmit_on_lock_only;
	logic        amplifier_enable, wakeup_enable, input_gain_select, supply_measure_select;
	logic [2:0]  transmit_level;
	logic [1:0]  receive_code_select, tx_code_index;
	logic        transmit_code_select, crystal_select, discriminator_range, data_polarity;
	logic        slicer_reference_select, adc_discriminator_select, transmit_allowed, amplifier_active;
	logic        wakeup_active, recovered_clock_pin, radio_data_pin, data_valid, oe;
	logic [5:0]  m_seq [0:6] = '{6'h0b, 6'h0c, 6'h09, 6'h08, 6'h07, 6'h0a, 6'h0d};
	logic [6:0]  v_seq = 7'h4e;
	int          err_count = 0;
	int          checked = 0;

	ccr_main_control i_dut (.mclk(mclk), .rst(rst), .ce(ce), .ser_enable_n(ser_enable_n), .ser_clk(ser_clk),
		.ser_data_in(ser_data_in), .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe),
		.synth_lock_flag(synth_lock_flag), .recovered_clock_in(recovered_clock_in), .demod_data(demod_data),
		.tx_data(tx_data), .strength_sample(strength_sample), .measured_strength(measured_strength),
		.main_control(main_control), .general_power_on(general_power_on), .direction_select(direction_select),
		.recovered_clock_enable(recovered_clock_enable), .transmit_on_lock_only(transmit_on_lock_only),
		.amplifier_enable(amplifier_enable), .wakeup_enable(wakeup_enable), .input_gain_select(input_gain_select),
		.supply_measure_select(supply_measure_select), .transmit_level(transmit_level),
		.transmit_code_select(transmit_code_select), .receive_code_select(receive_code_select),
		.crystal_select(crystal_select), .discriminator_range(discriminator_range), .data_polarity(data_polarity),
		.slicer_reference_select(slicer_reference_select), .adc_discriminator_select(adc_discriminator_select),
		.transmit_allowed(transmit_allowed), .amplifier_active(amplifier_active), .wakeup_active(wakeup_active),
		.tx_code_index(tx_code_index), .recovered_clock_pin(recovered_clock_pin), .radio_data_pin(radio_data_pin),
		.data_valid(data_valid));

	ccr_host_model i_host (.mclk(mclk), .ser_enable_n(ser_enable_n), .ser_clk(ser_clk), .ser_data_in(ser_data_in),
		.ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#10;
	endtask : cyc

	task automatic wr(input logic [3:0] a, input int n, input logic [31:0] v);
		logic [31:0] dummy;
		logic        seen;
		i_host.xfer(a, 1'b1, n, v, dummy, seen);
	endtask : wr

	task automatic rd(input logic [3:0] a);
		i_host.xfer(a, 1'b0, 32, 32'h0000_0000, d, oe);
	endtask : rd

	// Each pulse is followed by settling time for the registered pin
	task automatic sample(input logic [5:0] m);
		measured_strength = m;
		strength_sample   = 1'b1;
		cyc(1);
		strength_sample = 1'b0;
		cyc(3);
	endtask : sample

	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		$display("unexpected at %0t: run did not complete", $time);
		finish_test();
	end

	initial begin
		rst                = 1'b1;
		ce                 = 1'b1;
		synth_lock_flag    = 1'b0;
		recovered_clock_in = 1'b0;
		demod_data         = 1'b0;
		tx_data            = 1'b0;
		strength_sample    = 1'b0;
		measured_strength  = 6'h00;
		w = {8'hbe, 6'h0a, 3'h2, 3'h5, 1'b1, 1'b0, 2'h1, 4'h7, 4'h0};
		repeat (12) @(posedge mclk);
		#10 rst = 1'b0;
		cyc(1);
		chk(main_control, 32'h1000_0270);
		rd(4'h4);
		chk(d, 32'h1000_0270);
		chk(32'(oe), 32'h0000_0001);
		wr(4'h4, 32, w);
		chk(main_control, w);
		rd(4'h4);
		chk(d, w);
		chk(32'({general_power_on, direction_select, recovered_clock_enable, amplifier_enable, wakeup_enable,
			input_gain_select, supply_measure_select}), 32'h0000_005e);
		chk(32'({transmit_level, transmit_code_select, receive_code_select, data_polarity}), 32'h0000_005b);
		chk(32'({crystal_select, discriminator_range, slicer_reference_select, adc_discriminator_select,
			transmit_on_lock_only}), 32'h0000_000d);
		recovered_clock_in = 1'b1;
		tx_data            = 1'b1;
		cyc(2);
		chk(32'({recovered_clock_pin, amplifier_active, wakeup_active, transmit_allowed, tx_code_index}),
			32'h0000_003b);
		recovered_clock_in = 1'b0;
		cyc(2);
		chk(32'(recovered_clock_pin), 32'h0000_0000);
		demod_data = 1'b1;
		for (int i = 0; i < 7; i++) begin
			sample(m_seq[i]);
			chk(32'({data_valid, radio_data_pin}), 32'({v_seq[i], v_seq[i]}));
		end
		// Partial writes touch only the top bits
		wr(4'h4, 4, 32'h4000_0000);
		chk(main_control, {4'h4, w[27:0]});
		chk(32'({transmit_allowed, amplifier_active, radio_data_pin}), 32'h0000_0000);
		wr(4'h4, 4, 32'hc000_0000);
		chk(32'({transmit_allowed, radio_data_pin}), 32'h0000_0002);
		wr(4'h4, 4, 32'hd000_0000);
		chk(32'(transmit_allowed), 32'h0000_0000);
		synth_lock_flag = 1'b1;
		cyc(1);
		chk(32'(transmit_allowed), 32'h0000_0001);
		wr(4'h5, 32, 32'h0000_0000);
		chk(main_control, {4'hd, w[27:0]});
		rd(4'h5);
		chk(32'(oe), 32'h0000_0000);
		wr(4'h4, 32, w & ~32'h0000_0020);
		cyc(2);
		chk(32'(radio_data_pin), 32'h0000_0000);
		demod_data = 1'b0;
		cyc(3);
		chk(32'(radio_data_pin), 32'h0000_0001);
		// Frozen clock enable must swallow a low sample
		ce = 1'b0;
		sample(6'h07);
		ce = 1'b1;
		chk(32'(data_valid), 32'h0000_0001);
		wr(4'h4, 32, w | 32'h0100_0000);
		sample(6'h07);
		chk(32'({supply_measure_select, data_valid}), 32'h0000_0003);
		rst = 1'b1;
		cyc(1);
		chk(main_control, 32'h1000_0270);
		chk(32'(data_valid), 32'h0000_0000);
		rst = 1'b0;
		rd(4'h4);
		chk(d, 32'h1000_0270);
		finish_test();
	end
endmodule : ccr_main_control_bench
